// ---- logic/qdl_pkg.sv ----
// Shared constants and types for the quad converter serial load link
package qdl_pkg;
   // Word and channel geometry
   localparam int WORD_W     = 24;   // One frame carries one word
   localparam int CH_N       = 4;    // Converter channels
   localparam int CH_W       = 2;    // Channel index width
   localparam int CODE_W     = 16;   // Converter code width
   localparam int BITCNT_W   = 5;    // Bit counter, saturates past a word
   // Word field positions
   localparam int BIT_READ   = 23;   // Readback request
   localparam int BIT_CONFIG = 22;   // Configuration word
   localparam int CH_LSB     = 16;   // Channel field low bit
   localparam int CFG_CLRMID = 0;    // Config: clear to midscale
   localparam int CFG_BIPOL  = 1;    // Config: bipolar range
   // Clear target codes, straight binary
   localparam logic [CODE_W-1:0] CODE_ZERO = 16'h0000;
   localparam logic [CODE_W-1:0] CODE_MID  = 16'h8000;
   // Pin synchroniser lanes and their idle reset levels
   localparam int LN_FRAME  = 0;
   localparam int LN_SCLK   = 1;
   localparam int LN_SDI    = 2;
   localparam int LN_LOAD   = 3;
   localparam int LN_CLEAR  = 4;
   localparam int LN_CODING = 5;
   localparam int LN_N      = 6;
   localparam logic [LN_N-1:0] SYNC_RST = 6'h13;
   // Timing
   localparam int CLK_NS         = 4;    // Core clock period
   localparam int SCLK_MAX_MHZ   = 30;   // Fastest shift clock on writes
   localparam int SCLK_RB_MIN_NS = 90;   // Least period for readback
   localparam int SCLK_PERIOD_NS = 96;   // Period the host generates
   localparam int FRAME_GAP_NS   = 200;  // Frame-select high between frames
   localparam int SCLK_HALF_CYC  = (SCLK_PERIOD_NS / 2 + CLK_NS - 1) / CLK_NS;
   localparam int GAP_CYC        = (FRAME_GAP_NS + CLK_NS - 1) / CLK_NS;
   localparam int CNT_W          = 6;
   localparam logic [CNT_W-1:0] HALF_LD = CNT_W'(SCLK_HALF_CYC - 1);
   localparam logic [CNT_W-1:0] GAP_LD  = CNT_W'(GAP_CYC - 1);
   // Host sequencer states
   typedef enum logic [2:0] {
      QDL_IDLE,
      QDL_HIGH,
      QDL_LOW,
      QDL_TAIL,
      QDL_GAP
   } qdl_host_state_e;
endpackage

// ---- logic/qdl_link_if.sv ----
// Serial load link between host controller and converter front end
`timescale 1ns/1ps
interface qdl_link_if;
   logic frameN;        // Frame select, active low
   logic sclk;          // Shift clock, idles high
   logic serialIn;      // Host to converter data
   logic serialOut;     // Converter to host data
   logic loadOutputsN;  // Load line, active low
   logic clearN;        // Clear line, active low
   logic codingSelect;  // Bipolar coding strap

   // Converter end
   modport dev (
      input  frameN,
      input  sclk,
      input  serialIn,
      input  loadOutputsN,
      input  clearN,
      input  codingSelect,
      output serialOut
   );

   // Host end
   modport host (
      output frameN,
      output sclk,
      output serialIn,
      output loadOutputsN,
      output clearN,
      output codingSelect,
      input  serialOut
   );
endinterface

// ---- logic/qdl_device.sv ----
// Converter end: serial shift register, input and converter registers
//
// Contract
// - Bipolar: strap high offset binary, low twos
// - Unipolar ranges always use straight binary coding
// - Strap is tied static by the board
// - Frame select low; bits accepted only then
// - Word latched on frame select rising edge
// - One bit shifted per shift clock fall
// - Host shift clock at most 30 MHz
// - Host data stable at shift clock fall
// - Load low: addressed output updates at frame end
// - Load high: input register only, output deferred
// - Load falling edge updates all pending outputs
// - Load line always driven, never floating
// - Clear low forces outputs to zero or mid
// - Shift register contents leave on serial output
// - Output changes on rise, sampled on fall
// - Each frame carries exactly one 24-bit word
// - Readback shift clock period at least 90 ns
`timescale 1ns/1ps
module qdl_device (
   input  wire logic                              clock,
   input  wire logic                              rst,
   qdl_link_if.dev                                link,
   output logic [qdl_pkg::CH_N*qdl_pkg::CODE_W-1:0] dacCodes,
   output logic                                   rangeBipolar,
   output logic                                   clearTargetMid
);
   import qdl_pkg::*;

   // Pin synchroniser stages and edge history
   logic [LN_N-1:0]     pinMeta_reg;    // First stage, read only by second
   logic [LN_N-1:0]     pinSync_reg;    // Second stage, safe to use
   logic [LN_N-1:0]     pinPrev_reg;    // One cycle older, for edges
   logic [LN_N-1:0]     pinSample;      // Packed pin levels

   // Serial shift path
   logic [WORD_W-1:0]   shift_reg;      // Serial shift register
   logic [BITCNT_W-1:0] bitCnt_reg;     // Bits shifted this frame
   logic                serialOut_reg;  // Serial output driver

   // Configuration
   logic                cfgClearMid_reg; // Clear target select
   logic                cfgBipolar_reg;  // Output range is bipolar

   // Per channel storage
   logic [CODE_W-1:0]   inputCode_reg [CH_N];  // Input registers
   logic [CODE_W-1:0]   dacCode_reg   [CH_N];  // Converter registers
   logic [CH_N-1:0]     pending_reg;           // Deferred updates

   // Decoded events
   wire                 frameActive;
   wire                 frameRise;
   wire                 frameFall;
   wire                 sclkFall;
   wire                 sclkRise;
   wire                 loadLow;
   wire                 loadFall;
   wire                 clearActive;
   wire                 wordOk;
   wire                 isRead;
   wire                 isConfig;
   wire                 writeStrobe;
   wire                 twosComp;
   wire [CH_W-1:0]      wordCh;
   wire [CODE_W-1:0]    wordData;
   wire [CODE_W-1:0]    codeIn;
   wire [CODE_W-1:0]    clearCode;

   // Pin levels gathered into one vector
   assign pinSample[LN_FRAME]  = link.frameN;
   assign pinSample[LN_SCLK]   = link.sclk;
   assign pinSample[LN_SDI]    = link.serialIn;
   assign pinSample[LN_LOAD]   = link.loadOutputsN;
   assign pinSample[LN_CLEAR]  = link.clearN;
   assign pinSample[LN_CODING] = link.codingSelect;

   // Two-stage synchroniser; idle levels keep reset free of false edges
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pinMeta_reg <= SYNC_RST;
         pinSync_reg <= SYNC_RST;
         pinPrev_reg <= SYNC_RST;
      end else begin
         pinMeta_reg <= pinSample;
         pinSync_reg <= pinMeta_reg;
         pinPrev_reg <= pinSync_reg;
      end
   end

   // Frame window and edges of the frame select
   assign frameActive = ~pinSync_reg[LN_FRAME];
   assign frameRise   = pinSync_reg[LN_FRAME] & ~pinPrev_reg[LN_FRAME];
   assign frameFall   = ~pinSync_reg[LN_FRAME] & pinPrev_reg[LN_FRAME];

   // Shift clock edges count only inside a frame
   assign sclkFall = frameActive & ~pinSync_reg[LN_SCLK]
                     & pinPrev_reg[LN_SCLK];
   assign sclkRise = frameActive & pinSync_reg[LN_SCLK]
                     & ~pinPrev_reg[LN_SCLK];

   // Load and clear lines
   assign loadLow     = ~pinSync_reg[LN_LOAD];
   assign loadFall    = ~pinSync_reg[LN_LOAD] & pinPrev_reg[LN_LOAD];
   assign clearActive = ~pinSync_reg[LN_CLEAR];

   // A short or long frame is discarded whole
   assign wordOk = frameRise & (bitCnt_reg == BITCNT_W'(WORD_W));

   // Word field decode
   assign isRead      = shift_reg[BIT_READ];
   assign isConfig    = shift_reg[BIT_CONFIG];
   assign wordCh      = shift_reg[CH_LSB +: CH_W];
   assign wordData    = shift_reg[CODE_W-1:0];
   assign writeStrobe = wordOk & ~isRead & ~isConfig;

   // Twos complement only when bipolar and strap low; strap is static
   assign twosComp = cfgBipolar_reg & ~pinSync_reg[LN_CODING];
   // Stored codes are straight binary; flipping the sign bit converts
   assign codeIn   = {wordData[CODE_W-1] ^ twosComp,
                      wordData[CODE_W-2:0]};

   // Clear target from the persistent setting
   assign clearCode = cfgClearMid_reg ? CODE_MID : CODE_ZERO;

   // Shift register: sample on fall, reload for readback at frame end
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         shift_reg  <= '0;
         bitCnt_reg <= '0;
      end else if (frameFall) begin
         // New frame restarts the count, contents kept for daisy chain
         bitCnt_reg <= '0;
      end else if (sclkFall) begin
         shift_reg <= {shift_reg[WORD_W-2:0], pinSync_reg[LN_SDI]};
         // Saturate one past a word so overlong frames are refused
         if (bitCnt_reg <= BITCNT_W'(WORD_W)) begin
            bitCnt_reg <= bitCnt_reg + 1'b1;
         end
      end else if (wordOk && isRead) begin
         // Addressed converter code goes out during the next frame
         shift_reg <= {{(WORD_W-CODE_W){1'b0}}, dacCode_reg[wordCh]};
      end
   end

   // Serial output: MSB presented at frame start and after each rise
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         serialOut_reg <= 1'b0;
      end else if (frameFall || sclkRise) begin
         serialOut_reg <= shift_reg[WORD_W-1];
      end
   end

   // Configuration word; held until rewritten
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cfgClearMid_reg <= 1'b0;
         cfgBipolar_reg  <= 1'b0;
      end else if (wordOk && isConfig && !isRead) begin
         cfgClearMid_reg <= wordData[CFG_CLRMID];
         cfgBipolar_reg  <= wordData[CFG_BIPOL];
      end
   end

   // Per channel input and converter registers
   genvar ch;
   generate
      for (ch = 0; ch < CH_N; ch++) begin : gChan
         wire chWrite;   // This channel addressed by a write

         assign chWrite = writeStrobe & (wordCh == CH_W'(ch));

         // Input register always takes the written code
         always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
               inputCode_reg[ch] <= CODE_ZERO;
            end else if (chWrite) begin
               inputCode_reg[ch] <= codeIn;
            end
         end

         // Deferred flag; set by a write with load high, cleared by the load fall
         always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
               pending_reg[ch] <= 1'b0;
            end else if (chWrite && !loadLow) begin
               pending_reg[ch] <= 1'b1;
            end else if (loadFall) begin
               pending_reg[ch] <= 1'b0;
            end
         end

         // Converter register; clear dominates every update
         always_ff @(posedge clock or posedge rst) begin
            if (rst) begin
               dacCode_reg[ch] <= CODE_ZERO;
            end else if (clearActive) begin
               dacCode_reg[ch] <= clearCode;
            end else if (chWrite && loadLow) begin
               dacCode_reg[ch] <= codeIn;
            end else if (loadFall && pending_reg[ch]) begin
               dacCode_reg[ch] <= inputCode_reg[ch];
            end
         end

         // Flattened converter codes, channel 0 in the low bits
         assign dacCodes[ch*CODE_W +: CODE_W] = dacCode_reg[ch];
      end
   endgenerate

   // Remaining outputs straight from their registers
   assign link.serialOut  = serialOut_reg;
   assign rangeBipolar    = cfgBipolar_reg;
   assign clearTargetMid  = cfgClearMid_reg;
endmodule

// ---- logic/qdl_host.sv ----
// Host end: frames words onto the link and captures the serial output
`timescale 1ns/1ps
module qdl_host (
   input  wire logic                        clock,
   input  wire logic                        rst,
   qdl_link_if.host                         link,
   input  wire logic                        start,
   input  wire logic [qdl_pkg::WORD_W-1:0]  txWord,
   input  wire logic                        holdLoad,
   input  wire logic                        clearReq,
   input  wire logic                        codingHigh,
   output logic                             busy,
   output logic [qdl_pkg::WORD_W-1:0]       rxWord,
   output logic                             rxValid
);
   import qdl_pkg::*;

   qdl_host_state_e     state_reg;     // Frame sequencer
   logic [CNT_W-1:0]    cnt_reg;       // Half period and gap timer
   logic [BITCNT_W-1:0] bitIdx_reg;    // Falling edges issued
   logic [WORD_W-1:0]   txShift_reg;   // Outgoing bits, MSB first
   logic [WORD_W-1:0]   rxShift_reg;   // Captured serial output
   logic [WORD_W-1:0]   rxWord_reg;    // Last captured word
   logic                rxValid_reg;   // One-cycle pulse as frame select rises
   logic                busy_reg;      // Frame or gap in progress
   logic                frameN_reg;    // Frame select driver
   logic                sclk_reg;      // Shift clock driver, idles high
   logic                sdi_reg;       // Serial data driver
   logic                loadN_reg;     // Load line driver
   logic                clearN_reg;    // Clear line driver
   logic                coding_reg;    // Strap driver
   logic                sdoMeta_reg;   // First stage, read only by second
   logic                sdoSync_reg;   // Synchronised serial output
   wire                 cntDone;       // Timer expired

   assign cntDone = (cnt_reg == '0);

   // Serial output from the pin, two flip-flops before use
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sdoMeta_reg <= 1'b0;
         sdoSync_reg <= 1'b0;
      end else begin
         sdoMeta_reg <= link.serialOut;
         sdoSync_reg <= sdoMeta_reg;
      end
   end

   // Side lines always driven to a defined level; strap meant static
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         loadN_reg  <= 1'b0;
         clearN_reg <= 1'b1;
         coding_reg <= 1'b0;
      end else begin
         loadN_reg  <= ~holdLoad;
         clearN_reg <= ~clearReq;
         coding_reg <= codingHigh;
      end
   end

   // Frame sequencer; 96 ns period meets write and readback limits
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state_reg   <= QDL_IDLE;
         cnt_reg     <= '0;
         bitIdx_reg  <= '0;
         txShift_reg <= '0;
         rxShift_reg <= '0;
         rxWord_reg  <= '0;
         rxValid_reg <= 1'b0;
         busy_reg    <= 1'b0;
         frameN_reg  <= 1'b1;
         sclk_reg    <= 1'b1;
         sdi_reg     <= 1'b0;
      end else begin
         rxValid_reg <= 1'b0;
         if (!cntDone) begin
            cnt_reg <= cnt_reg - 1'b1;
         end
         unique case (state_reg)
            QDL_IDLE: if (start) begin
               // Frame select low for the whole transfer
               frameN_reg  <= 1'b0;
               busy_reg    <= 1'b1;
               txShift_reg <= txWord;
               sdi_reg     <= txWord[WORD_W-1];
               bitIdx_reg  <= '0;
               cnt_reg     <= HALF_LD;
               state_reg   <= QDL_HIGH;
            end
            QDL_HIGH: if (cntDone) begin
               // Falling edge: data has stood a half period
               sclk_reg    <= 1'b0;
               rxShift_reg <= {rxShift_reg[WORD_W-2:0], sdoSync_reg};
               bitIdx_reg  <= bitIdx_reg + 1'b1;
               cnt_reg     <= HALF_LD;
               state_reg   <= QDL_LOW;
            end
            QDL_LOW: if (cntDone) begin
               sclk_reg <= 1'b1;
               cnt_reg  <= HALF_LD;
               if (bitIdx_reg == BITCNT_W'(WORD_W)) begin
                  state_reg <= QDL_TAIL;
               end else begin
                  txShift_reg <= {txShift_reg[WORD_W-2:0], 1'b0};
                  sdi_reg     <= txShift_reg[WORD_W-2];
                  state_reg   <= QDL_HIGH;
               end
            end
            QDL_TAIL: if (cntDone) begin
               frameN_reg  <= 1'b1;
               rxWord_reg  <= rxShift_reg;
               rxValid_reg <= 1'b1;
               cnt_reg     <= GAP_LD;
               state_reg   <= QDL_GAP;
            end
            QDL_GAP: if (cntDone) begin
               busy_reg  <= 1'b0;
               state_reg <= QDL_IDLE;
            end
         endcase
      end
   end

   // Outputs straight from registers
   assign link.frameN       = frameN_reg;
   assign link.sclk         = sclk_reg;
   assign link.serialIn     = sdi_reg;
   assign link.loadOutputsN = loadN_reg;
   assign link.clearN       = clearN_reg;
   assign link.codingSelect = coding_reg;
   assign busy              = busy_reg;
   assign rxWord            = rxWord_reg;
   assign rxValid           = rxValid_reg;
endmodule

// ---- dv/qdl_link_sva.sv ----
// Checker for the serial load link between host and converter ends
`timescale 1ns/1ps
module qdl_link_sva (
   input wire logic clock,
   input wire logic rst,
   input wire logic frameN,
   input wire logic sclk,
   input wire logic serialIn,
   input wire logic serialOut,
   input wire logic loadOutputsN,
   input wire logic clearN,
   input wire logic codingSelect
);
   logic       sclkQ;    // Shift clock one cycle ago
   logic       frameQ;   // Frame select one cycle ago
   logic [4:0] fallCnt;  // Shift clock falls inside this frame
   logic [5:0] hiCnt;    // Cycles frame select high, saturating
   logic [5:0] halfCnt;  // Cycles since last shift clock change
   wire        sclkFall  = sclkQ & ~sclk;    // Fall seen this cycle
   wire        sclkRise  = ~sclkQ & sclk;    // Rise seen this cycle
   wire        frameFall = frameQ & ~frameN; // Frame opens this cycle

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   // Delayed copies, idle high like the lines
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         sclkQ  <= 1'b1;
         frameQ <= 1'b1;
      end else begin
         sclkQ  <= sclk;
         frameQ <= frameN;
      end
   end

   // Count falls per frame; saturate so a runaway frame cannot wrap
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         fallCnt <= 5'h00;
      end else if (frameFall) begin
         fallCnt <= 5'h00;
      end else if (sclkFall && !frameN && fallCnt != 5'h1f) begin
         fallCnt <= fallCnt + 5'h01;
      end
   end

   // Gap and half period counters start saturated, so reset is no gap
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         hiCnt   <= 6'h3f;
         halfCnt <= 6'h3f;
      end else begin
         hiCnt   <= !frameN ? 6'h00 : (hiCnt == 6'h3f ? hiCnt : hiCnt + 6'h01);
         halfCnt <= (sclk != sclkQ) ? 6'h00
                    : (halfCnt == 6'h3f ? halfCnt : halfCnt + 6'h01);
      end
   end

   a_sclk_idle_high: assert property (frameN |-> sclk)
      else $error("shift clock low outside a frame");
   a_fall_in_frame: assert property ($fell(sclk) |-> !frameN)
      else $error("shift clock fell while frame select high");
   a_frame_setup: assert property ($fell(frameN) |-> sclk [*8])
      else $error("shift clock fell too soon after frame start");
   a_low_time: assert property ($fell(sclk) |=> !sclk [*8])
      else $error("shift clock low phase too short");
   a_half_period: assert property (
      $changed(sclk) |-> halfCnt >= 6'd11)
      else $error("shift clock half period below readback limit");
   a_data_stable: assert property (
      $fell(sclk) |-> $stable(serialIn) ##1 $stable(serialIn))
      else $error("serial input moved at shift clock fall");
   a_word_length: assert property (
      $rose(frameN) |-> fallCnt == 5'd24)
      else $error("frame did not carry one whole word");
   a_frame_gap: assert property ($fell(frameN) |-> hiCnt >= 6'd50)
      else $error("frame select high time too short");
   a_sdo_on_rise: assert property (
      $changed(serialOut) |-> $past(sclkRise, 3) || $past(frameFall, 3))
      else $error("serial output changed off a shift clock rise");
   a_strap_static: assert property ($stable(codingSelect))
      else $error("coding strap moved during operation");
endmodule

// ---- dv/quad_dac_serial_load_control_bench.sv ----
// Bench joining host and converter ends, plus a hand-driven second link
`timescale 1ns/1ps
module quad_dac_serial_load_control_bench;
   import qdl_pkg::*;
   logic                   clock;          // Core clock
   logic                   rst;            // Async reset
   logic                   start;          // Host frame request
   logic [WORD_W-1:0]      txWord;         // Word to send
   logic                   holdLoad;       // Load line held low
   logic                   clearReq;       // Clear line request
   logic                   codingHigh;     // Coding strap level
   logic                   busy;           // Host frame in progress
   logic [WORD_W-1:0]      rxWord;         // Word heard back
   logic                   rxValid;        // Frame end pulse
   logic [CH_N*CODE_W-1:0] dacCodes;       // Converter registers
   logic [CH_N*CODE_W-1:0] dacCodesB;      // Second converter registers
   logic                   rangeBipolar;   // Range set bipolar
   logic                   clearTargetMid; // Clear goes to midscale
   logic [WORD_W-1:0]      rxSeen;         // Last word heard back
   logic [WORD_W-1:0]      rxB;            // Second link output heard
   logic [CH_N*CODE_W-1:0] snap;           // Codes before deferred writes
   logic [CODE_W-1:0]      codes [CH_N];   // Boundary codes per channel
   int                     i;              // Channel loop index
   int                     n_fail;         // Mismatches
   int                     num_checks;     // Comparisons made
   qdl_link_if link ();                    // Host to first converter
   qdl_link_if linkB ();                   // Bench to second converter

   qdl_host u_qdl_host (.clock(clock), .rst(rst), .link(link.host),
      .start(start), .txWord(txWord), .holdLoad(holdLoad),
      .clearReq(clearReq), .codingHigh(codingHigh), .busy(busy),
      .rxWord(rxWord), .rxValid(rxValid));
   qdl_device u_qdl_device (.clock(clock), .rst(rst), .link(link.dev),
      .dacCodes(dacCodes), .rangeBipolar(rangeBipolar),
      .clearTargetMid(clearTargetMid));
   // Second converter sees rule-breaking frames from the bench
   qdl_device u_qdl_device_b (.clock(clock), .rst(rst), .link(linkB.dev),
      .dacCodes(dacCodesB), .rangeBipolar(), .clearTargetMid());
   qdl_link_sva u_qdl_link_sva (.clock(clock), .rst(rst),
      .frameN(link.frameN), .sclk(link.sclk), .serialIn(link.serialIn),
      .serialOut(link.serialOut), .loadOutputsN(link.loadOutputsN),
      .clearN(link.clearN), .codingSelect(link.codingSelect));

   // 250 MHz core clock
   always #2 clock = ~clock;

   // Compare and count
   task automatic check(input logic [63:0] seen, input logic [63:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_fail++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Verdict and end of run
   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, n_fail);
      if (n_fail == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Let edge updates land before sampling
   task automatic waitCyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask

   // One host frame; bounded waits for frame end and idle
   task automatic hostWr(input logic [WORD_W-1:0] w);
      int k;
      @(posedge clock);
      start  <= 1'b1;
      txWord <= w;
      @(posedge clock);
      start  <= 1'b0;
      k = 0;
      while (rxValid !== 1'b1 && k < 3000) begin
         @(posedge clock);
         #1;
         k++;
      end
      check({63'h0, rxValid}, 64'h1);
      rxSeen = rxWord;
      while (busy !== 1'b0 && k < 3000) begin
         @(posedge clock);
         #1;
         k++;
      end
      check({63'h0, busy}, 64'h0);
      waitCyc(8);
   endtask

   // Hand-made frame of n bits, MSB first, data moved on clock rise
   task automatic drvB(input logic [WORD_W-1:0] w, input int n);
      int b;
      @(posedge clock);
      linkB.frameN <= 1'b0;
      for (b = 0; b < n; b++) begin
         linkB.serialIn <= w[WORD_W-1-b];
         repeat (12) @(posedge clock);
         // Output moved three cycles after the rise, settled by now
         rxB = {rxB[WORD_W-2:0], linkB.serialOut};
         linkB.sclk <= 1'b0;
         repeat (12) @(posedge clock);
         linkB.sclk <= 1'b1;
      end
      repeat (12) @(posedge clock);
      linkB.frameN   <= 1'b1;
      linkB.serialIn <= ~linkB.serialIn; // Released line does not hold
      waitCyc(60);
   endtask

   // Watchdog well beyond the expected run length
   initial begin
      #120000;
      check(64'h0, 64'h1);
      summarize();
   end

   // Main sequence
   initial begin
      clock = 1'b0;
      rst = 1'b1;
      start = 1'b0;
      txWord = '0;
      holdLoad = 1'b1;
      clearReq = 1'b0;
      codingHigh = 1'b0;
      linkB.frameN = 1'b1;
      linkB.sclk = 1'b1;
      linkB.serialIn = 1'b0;
      linkB.loadOutputsN = 1'b0; // Tied low: direct updates
      linkB.clearN = 1'b1;       // Tied inactive
      linkB.codingSelect = 1'b1; // Tied strap
      codes = '{16'h0001, 16'h7fff, 16'h8000, 16'hffff};
      n_fail = 0;
      num_checks = 0;
      repeat (20) @(posedge clock);
      rst <= 1'b0;
      waitCyc(4);
      // Configuration: clear to midscale, unipolar
      hostWr(24'h400001);
      check({63'h0, clearTargetMid}, 64'h1);
      check({63'h0, rangeBipolar}, 64'h0);
      // Direct writes, strap low but unipolar stays straight
      for (i = 0; i < CH_N; i++) begin
         hostWr({6'h00, 2'(i), codes[i]});
         check({48'h0, dacCodes[CODE_W*i +: CODE_W]}, {48'h0, codes[i]});
      end
      // Readback: second frame carries the addressed code out
      hostWr(24'h810000);
      hostWr(24'h810000);
      check({40'h0, rxSeen}, {48'h0, codes[1]});
      // Deferred writes, then one load fall updates both
      snap = dacCodes;
      @(posedge clock);
      holdLoad <= 1'b0;
      hostWr(24'h00abcd);
      hostWr(24'h021357);
      check(dacCodes, snap);
      @(posedge clock);
      holdLoad <= 1'b1;
      waitCyc(10);
      check(dacCodes, {codes[3], 16'h1357, codes[1], 16'habcd});
      // Clear to midscale, then to zero after reconfiguring
      @(posedge clock);
      clearReq <= 1'b1;
      waitCyc(10);
      check(dacCodes, {CH_N{CODE_MID}});
      @(posedge clock);
      clearReq <= 1'b0;
      hostWr(24'h400000);
      check({63'h0, clearTargetMid}, 64'h0);
      @(posedge clock);
      clearReq <= 1'b1;
      waitCyc(10);
      check(dacCodes, {CH_N{CODE_ZERO}});
      @(posedge clock);
      clearReq <= 1'b0;
      // Bipolar on this link: twos complement MSB flipped; second link still unipolar, code kept
      hostWr(24'h400002);
      check({63'h0, rangeBipolar}, 64'h1);
      // Strap stays low on this link: twos complement, MSB flipped
      hostWr(24'h011234);
      check({48'h0, dacCodes[CODE_W +: CODE_W]}, 64'h9234);
      drvB(24'h02c3c3, 24);
      check({48'h0, dacCodesB[2*CODE_W +: CODE_W]}, 64'hc3c3);
      // Short frame is discarded
      drvB(24'h025a5a, 23);
      check({48'h0, dacCodesB[2*CODE_W +: CODE_W]}, 64'hc3c3);
      // Read request parks the code in the shift register
      drvB(24'h820000, 24);
      // Clock edges outside a frame must not shift it
      repeat (4) begin
         repeat (12) @(posedge clock);
         linkB.sclk <= ~linkB.sclk;
      end
      // Next frame carries it out and sets the range bipolar
      drvB(24'h400002, 24);
      check({40'h0, rxB}, 64'h00c3c3);
      // Strap tied high here: offset binary passes unchanged
      drvB(24'h011234, 24);
      check({48'h0, dacCodesB[CODE_W +: CODE_W]}, 64'h1234);
      summarize();
   end
endmodule
